// ### rtl/nsp_top.sv
// negative sequence overcurrent protection: two DT stages, one inverse
// Functional notes
// - filter phase fundamentals and derive the negative sequence magnitude.
// - compare only when max phase above minimum and all below 4x rated.
// - low stage over threshold starts its timer and raises low pickup.
// - high stage over threshold starts its own timer and pickup.
// - a stage timer reaching its delay issues that stage's trip.
// - inverse stage curve is IEC or ANSI; DT stages run in parallel.
// - power-proportional characteristic may replace the inverse curve.
// - inverse pickup only above 1.1 times its setting.
// - inverse trip once curve time for the measured current elapses.
// - inverse dropout selectable: immediate or disk emulation.
// - immediate dropout below 95 percent of the setting.
// - immediate dropout clears the time accumulator.
// - disk emulation decrements the accumulator below 90 percent.
// - disk emulation holds the accumulator between 90 and 95 percent.
// - disk emulation clears the accumulator below 5 percent.
// - block input resets all pickups and stage timers.
// - leaving the operating range drops every stage pickup.
// - modes off, on, and on with the trip relay suppressed.
`timescale 1ns/100ps
`include "nsp_regs.svh"
module nsp_top #(
  parameter int unsigned PROC_DIV = `NSP_PROC_NS / `NSP_CLK_NS
) (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                sampleValid,
  input  wire nsp_pkg::nsp_smp_t   sampleA,
  input  wire nsp_pkg::nsp_smp_t   sampleB,
  input  wire nsp_pkg::nsp_smp_t   sampleC,
  input  wire logic                blockIn,
  input  wire nsp_pkg::nsp_mode_t  mode,
  input  wire nsp_pkg::nsp_curve_t curve,
  input  wire nsp_pkg::nsp_drop_t  dropMode,
  input  wire nsp_pkg::nsp_mag_t   ratedCurrent,
  input  wire nsp_pkg::nsp_mag_t   minimumCurrentSetting,
  input  wire nsp_pkg::nsp_mag_t   lowStageThreshold,
  input  wire nsp_pkg::nsp_mag_t   highStageThreshold,
  input  wire logic [15:0]         lowStageDelay,
  input  wire logic [15:0]         highStageDelay,
  input  wire nsp_pkg::nsp_mag_t   inverseStageSetting,
  input  wire nsp_pkg::nsp_mag_t   timeMultiplier,
  input  wire nsp_pkg::nsp_mag_t   powerConstant,
  output nsp_pkg::nsp_mag_t        negativeSequenceCurrent,
  output logic                     lowPickup,
  output logic                     highPickup,
  output logic                     invPickup,
  output logic                     lowTrip,
  output logic                     highTrip,
  output logic                     invTrip,
  output logic                     tripRelay
);
  import nsp_pkg::*;

  nsp_link_if lnk ();

  logic [31:0] divCnt;
  logic [31:0] next_divCnt;
  logic        procTick;
  logic        next_procTick;
  logic [2:0]  blkSync;
  logic        blk;
  logic        next_blk;
  logic        run;
  logic        inRange;
  logic        act;
  nsp_mag_t    i2Eff;
  nsp_mag_t    maxPhase;
  logic        invAbove;
  logic        below95;
  logic        below90;
  logic        below5;
  logic        next_lowPickup;
  logic        next_highPickup;
  logic        next_invPickup;
  logic        next_lowTrip;
  logic        next_highTrip;
  logic        next_invTrip;
  logic        next_tripRelay;
  logic [15:0] lowCnt;
  logic [15:0] next_lowCnt;
  logic [15:0] highCnt;
  logic [15:0] next_highCnt;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [32:0] accSum;

  nsp_seq_calc uSeq (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .sampleValid (sampleValid),
    .sampleA     (sampleA),
    .sampleB     (sampleB),
    .sampleC     (sampleC),
    .lnk         (lnk.seq)
  );

  nsp_inv_curve uInv (
    .mclk  (mclk),
    .rst_b (rst_b),
    .lnk   (lnk.inv)
  );

  // a * na > b * nb, used for every percentage threshold
  function automatic logic gtScaled(input nsp_mag_t a, input nsp_mag_t b,
                                    input logic [4:0] na,
                                    input logic [4:0] nb);
    return (21'(a) * 21'(na)) > (21'(b) * 21'(nb));
  endfunction : gtScaled

  // counts processing cycles while picked up, saturates at full scale
  function automatic logic [15:0] stepTimer(input logic pu,
                                            input logic [15:0] c);
    if (!pu)
      return `NSP_CNT_RST;
    return (c == 16'hffff) ? c : c + 16'h0001;
  endfunction : stepTimer

  // processing cycle divider and block input synchroniser
  always_comb
  begin
    next_procTick = (divCnt == 32'(PROC_DIV - 1));
    next_divCnt   = next_procTick ? 32'h0000_0000 : divCnt + 32'h0000_0001;
    // a change counts once the last two stages agree
    next_blk      = (blkSync[1] == blkSync[2]) ? blkSync[2] : blk;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divCnt   <= 32'h0000_0000;
      procTick <= 1'b0;
      blkSync  <= 3'h0;
      blk      <= 1'b0;
    end
    else
    begin
      divCnt   <= next_divCnt;
      procTick <= next_procTick;
      blkSync  <= {blkSync[1:0], blockIn};
      blk      <= next_blk;
    end
  end

  // operating range and effective current seen by the stages
  always_comb
  begin
    maxPhase = (lnk.magA > lnk.magB) ? lnk.magA : lnk.magB;
    maxPhase = (maxPhase > lnk.magC) ? maxPhase : lnk.magC;
    run      = ((mode == NSP_ON) || (mode == NSP_RELAY_BLK)) && !blk;
    inRange  = (maxPhase > minimumCurrentSetting)
            && !gtScaled(lnk.magA, ratedCurrent, `NSP_ONE, `NSP_OVR_MUL)
            && !gtScaled(lnk.magB, ratedCurrent, `NSP_ONE, `NSP_OVR_MUL)
            && !gtScaled(lnk.magC, ratedCurrent, `NSP_ONE, `NSP_OVR_MUL);
    act      = run && inRange;
    // out of range looks like zero current, so every pickup drops
    i2Eff    = act ? lnk.i2 : 16'h0000;
    invAbove = gtScaled(i2Eff, inverseStageSetting,
                        `NSP_INV_PU_D, `NSP_INV_PU_N);
    below95  = gtScaled(inverseStageSetting, i2Eff,
                        `NSP_DROP_N, `NSP_DROP_D);
    below90  = gtScaled(inverseStageSetting, i2Eff,
                        `NSP_DISK_N, `NSP_DISK_D);
    below5   = gtScaled(inverseStageSetting, i2Eff,
                        `NSP_DONE_N, `NSP_DONE_D);
  end

  // curve request goes out each cycle, rates are ready long before next
  assign lnk.invStart = procTick;
  assign lnk.invSet   = inverseStageSetting;
  assign lnk.timeMult = timeMultiplier;
  assign lnk.powerK   = powerConstant;
  assign lnk.curve    = curve;

  // stage logic, evaluated once per processing cycle
  always_comb
  begin
    next_lowPickup  = lowPickup;
    next_highPickup = highPickup;
    next_invPickup  = invPickup;
    next_lowCnt     = lowCnt;
    next_highCnt    = highCnt;
    next_lowTrip    = lowTrip;
    next_highTrip   = highTrip;
    next_invTrip    = invTrip;
    next_acc        = acc;
    accSum          = 33'(acc) + 33'(lnk.incRate);
    if (!run)
    begin
      next_lowPickup  = 1'b0;
      next_highPickup = 1'b0;
      next_invPickup  = 1'b0;
      next_lowCnt     = `NSP_CNT_RST;
      next_highCnt    = `NSP_CNT_RST;
      next_lowTrip    = 1'b0;
      next_highTrip   = 1'b0;
      next_invTrip    = 1'b0;
      next_acc        = `NSP_ACC_RST;
    end
    else if (procTick)
    begin
      next_lowPickup  = i2Eff > lowStageThreshold;
      next_highPickup = i2Eff > highStageThreshold;
      next_lowCnt     = stepTimer(next_lowPickup, lowCnt);
      next_highCnt    = stepTimer(next_highPickup, highCnt);
      next_lowTrip    = next_lowPickup
                     && (next_lowCnt >= lowStageDelay);
      next_highTrip   = next_highPickup
                     && (next_highCnt >= highStageDelay);
      if (invAbove)
        next_invPickup = 1'b1;
      // a zero setting never reads as below 95, so range loss drops it too
      else if (below95 || !act)
        next_invPickup = 1'b0;
      if (next_invPickup)
        next_acc = accSum[32] ? 32'hffff_ffff : accSum[31:0];
      else if (dropMode == NSP_DROP_IMM)
        next_acc = `NSP_ACC_RST;
      else if (below5)
        next_acc = `NSP_ACC_RST;
      else if (below90)
        next_acc = (acc > 32'(lnk.decRate))
                 ? acc - 32'(lnk.decRate) : `NSP_ACC_RST;
      // between 90 and 95 percent the accumulator simply holds
      else
        next_acc = acc;
      next_invTrip = next_invPickup && (next_acc >= lnk.invLimit);
    end
    // stages are independent, so whichever is fastest trips first
    next_tripRelay = (mode == NSP_ON) && !blk
                  && (lowTrip || highTrip || invTrip);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lowPickup  <= 1'b0;
      highPickup <= 1'b0;
      invPickup  <= 1'b0;
      lowTrip    <= 1'b0;
      highTrip   <= 1'b0;
      invTrip    <= 1'b0;
      tripRelay  <= 1'b0;
      lowCnt     <= `NSP_CNT_RST;
      highCnt    <= `NSP_CNT_RST;
      acc        <= `NSP_ACC_RST;
      negativeSequenceCurrent <= 16'h0000;
    end
    else
    begin
      lowPickup  <= next_lowPickup;
      highPickup <= next_highPickup;
      invPickup  <= next_invPickup;
      lowTrip    <= next_lowTrip;
      highTrip   <= next_highTrip;
      invTrip    <= next_invTrip;
      tripRelay  <= next_tripRelay;
      lowCnt     <= next_lowCnt;
      highCnt    <= next_highCnt;
      acc        <= next_acc;
      negativeSequenceCurrent <= lnk.i2;
    end
  end

  chk_block_reset: assert property (
    @(posedge mclk) disable iff (!rst_b)
    blk |=> !lowPickup && !highPickup && !invPickup && acc == 32'h0000_0000
  ) else $error("block did not clear the stages");

  chk_range_drop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick && !inRange |=> !lowPickup && !highPickup && !invPickup
  ) else $error("pickup held outside operating range");

  chk_high_pickup: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick && act && lnk.i2 > highStageThreshold |=> highPickup
  ) else $error("high stage did not pick up");

  chk_low_delay: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(lowTrip) |-> lowPickup && lowCnt >= lowStageDelay
  ) else $error("low stage tripped before its delay");

  chk_inv_pickup: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(invPickup) |-> $past(invAbove) && $past(procTick)
  ) else $error("inverse pickup below 1.1 times setting");

  chk_imm_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(invPickup) && $past(dropMode) == NSP_DROP_IMM
      |-> acc == 32'h0000_0000
  ) else $error("accumulator kept after immediate dropout");

  chk_disk_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick && run && dropMode == NSP_DROP_DISK && !next_invPickup
      && !below90 |=> $stable(acc)
  ) else $error("accumulator moved in the hold band");

  chk_disk_decay: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick && run && dropMode == NSP_DROP_DISK && !next_invPickup
      && below90 && !below5 && acc != 32'h0000_0000 |=> acc < $past(acc)
  ) else $error("accumulator did not decay below 90 percent");

  chk_disk_done: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick && run && below5 && !next_invPickup |=> acc == 32'h0000_0000
  ) else $error("accumulator not cleared below 5 percent");

  chk_relay_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    mode != NSP_ON |=> !tripRelay
  ) else $error("trip relay driven while suppressed");

  chk_tick_single: assert property (
    @(posedge mclk) disable iff (!rst_b)
    procTick |=> !procTick [*2]
  ) else $error("processing cycle pulse too long");
endmodule : nsp_top

// ### rtl/nsp_regs.svh
// timing counts, scale factors and reset values of the nsp block
`ifndef NSP_REGS_SVH
`define NSP_REGS_SVH
`define NSP_CLK_NS 4
`define NSP_PROC_NS 1_000_000
`define NSP_PROC_PER_S (1_000_000_000 / `NSP_PROC_NS)
`define NSP_OVR_MUL 5'h04
`define NSP_ONE 5'h01
`define NSP_INV_PU_N 5'h0b
`define NSP_INV_PU_D 5'h0a
`define NSP_DROP_N 5'h13
`define NSP_DROP_D 5'h14
`define NSP_DISK_N 5'h09
`define NSP_DISK_D 5'h0a
`define NSP_DONE_N 5'h01
`define NSP_DONE_D 5'h14
`define NSP_SIN60 17'h0_376d
`define NSP_THIRD 15'h1555
`define NSP_Q8_ONE 16'h0100
`define NSP_K_IEC_VI 16'h0d80
`define NSP_K_IEC_EI 16'h5000
`define NSP_K_ANSI_VI 16'h03ec
`define NSP_DIV_LAST 5'h17
`define NSP_ACC_RST 32'h0000_0000
`define NSP_CNT_RST 16'h0000
`endif

// ### rtl/nsp_pkg.sv
// types shared by the nsp block
package nsp_pkg;
  typedef logic signed [15:0] nsp_smp_t;
  typedef logic [15:0] nsp_mag_t;
  typedef enum logic [1:0] {
    NSP_OFF       = 2'b00,
    NSP_ON        = 2'b01,
    NSP_RELAY_BLK = 2'b10
  } nsp_mode_t;
  typedef enum logic [1:0] {
    NSP_IEC_VI  = 2'b00,
    NSP_IEC_EI  = 2'b01,
    NSP_ANSI_VI = 2'b10,
    NSP_POWER   = 2'b11
  } nsp_curve_t;
  typedef enum logic {
    NSP_DROP_IMM  = 1'b0,
    NSP_DROP_DISK = 1'b1
  } nsp_drop_t;
  typedef enum logic {
    NSP_DIV_IDLE = 1'b0,
    NSP_DIV_RUN  = 1'b1
  } nsp_div_t;
endpackage : nsp_pkg

// ### rtl/nsp_link_if.sv
// measurement and curve signals between the nsp modules
`timescale 1ns/100ps
interface nsp_link_if;
  import nsp_pkg::*;
  nsp_mag_t   magA;
  nsp_mag_t   magB;
  nsp_mag_t   magC;
  nsp_mag_t   i2;
  logic       invStart;
  nsp_mag_t   invSet;
  nsp_mag_t   timeMult;
  nsp_mag_t   powerK;
  nsp_curve_t curve;
  nsp_mag_t   incRate;
  nsp_mag_t   decRate;
  logic [31:0] invLimit;
  modport seq (output magA, magB, magC, i2);
  modport inv (input i2, invStart, invSet, timeMult, powerK, curve,
               output incRate, decRate, invLimit);
  modport top (input magA, magB, magC, i2, incRate, decRate, invLimit,
               output invStart, invSet, timeMult, powerK, curve);
endinterface : nsp_link_if

// ### rtl/nsp_seq_calc.sv
// fundamental phasors, phase magnitudes and negative sequence magnitude
`timescale 1ns/100ps
`include "nsp_regs.svh"
module nsp_seq_calc (
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             sampleValid,
  input wire nsp_pkg::nsp_smp_t sampleA,
  input wire nsp_pkg::nsp_smp_t sampleB,
  input wire nsp_pkg::nsp_smp_t sampleC,
  nsp_link_if.seq              lnk
);
  import nsp_pkg::*;

  nsp_smp_t          hist      [0:2][0:3];
  nsp_smp_t          next_hist [0:2][0:3];
  nsp_smp_t          smp       [0:2];
  logic signed [18:0] re       [0:2];
  logic signed [18:0] im       [0:2];
  logic signed [18:0] sr;
  logic signed [18:0] si;
  nsp_mag_t          mag       [0:3];
  nsp_mag_t          next_mag  [0:3];

  function automatic logic signed [18:0] sin60(input logic signed [18:0] x);
    logic signed [35:0] p;
    p = 36'(x) * 36'(signed'({1'b0, `NSP_SIN60}));
    return p[32:14];
  endfunction : sin60

  // max plus 3/8 min, within about 7 percent of the true modulus
  function automatic logic [18:0] magOf(input logic signed [18:0] x,
                                        input logic signed [18:0] y);
    logic [18:0] ax;
    logic [18:0] ay;
    logic [18:0] mx;
    logic [18:0] mn;
    ax = x[18] ? 19'(-x) : 19'(x);
    ay = y[18] ? 19'(-y) : 19'(y);
    mx = (ax > ay) ? ax : ay;
    mn = (ax > ay) ? ay : ax;
    return mx + (mn >> 2) + (mn >> 3);
  endfunction : magOf

  function automatic logic [18:0] third(input logic [18:0] m);
    logic [33:0] p;
    p = 34'(m) * 34'(`NSP_THIRD);
    return p[32:14];
  endfunction : third

  function automatic nsp_mag_t sat16(input logic [18:0] m);
    return (m[18:16] != 3'h0) ? 16'hffff : m[15:0];
  endfunction : sat16

  // four samples per period: x0-x2 and x1-x3 give the fundamental
  always_comb
  begin
    smp[0] = sampleA;
    smp[1] = sampleB;
    smp[2] = sampleC;
    next_hist = hist;
    for (int p = 0; p < 3; p++)
    begin
      if (sampleValid)
      begin
        for (int k = 3; k > 0; k--)
          next_hist[p][k] = hist[p][k-1];
        next_hist[p][0] = smp[p];
      end
      re[p] = 19'(hist[p][0]) - 19'(hist[p][2]);
      im[p] = 19'(hist[p][1]) - 19'(hist[p][3]);
      next_mag[p] = sat16(magOf(re[p], im[p]));
    end
    // (A + a^2 B + a C) / 3 with a = 120 degree rotation
    sr = re[0] - ((re[1] + re[2]) >>> 1) + sin60(im[1] - im[2]);
    si = im[0] - ((im[1] + im[2]) >>> 1) - sin60(re[1] - re[2]);
    next_mag[3] = sat16(third(magOf(sr, si)));
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int p = 0; p < 3; p++)
        for (int k = 0; k < 4; k++)
          hist[p][k] <= 16'sh0000;
      for (int m = 0; m < 4; m++)
        mag[m] <= 16'h0000;
    end
    else
    begin
      hist <= next_hist;
      mag  <= next_mag;
    end
  end

  assign lnk.magA = mag[0];
  assign lnk.magB = mag[1];
  assign lnk.magC = mag[2];
  assign lnk.i2   = mag[3];
endmodule : nsp_seq_calc

// ### rtl/nsp_inv_curve.sv
// serial ratio divider and inverse curve rates for the inverse stage
`timescale 1ns/100ps
`include "nsp_regs.svh"
module nsp_inv_curve (
  input wire logic mclk,
  input wire logic rst_b,
  nsp_link_if.inv  lnk
);
  import nsp_pkg::*;

  nsp_div_t    state;
  nsp_div_t    next_state;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [16:0] rem;
  logic [16:0] next_rem;
  logic [16:0] trial;
  logic [23:0] num;
  logic [23:0] next_num;
  logic [23:0] quo;
  logic [23:0] next_quo;
  nsp_mag_t    ratio;
  nsp_mag_t    next_ratio;
  logic [31:0] sqFull;
  nsp_mag_t    sq;
  nsp_mag_t    kSel;
  logic [31:0] kt;

  // restoring division, ratio = i2 / setting in Q8, 24 steps
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_rem   = rem;
    next_num   = num;
    next_quo   = quo;
    next_ratio = ratio;
    trial      = {rem[15:0], num[23]};
    unique case (state)
      NSP_DIV_IDLE:
        if (lnk.invStart)
        begin
          next_num   = {lnk.i2, 8'h00};
          next_rem   = 17'h0_0000;
          next_quo   = 24'h00_0000;
          next_cnt   = 5'h00;
          next_state = NSP_DIV_RUN;
        end
      NSP_DIV_RUN:
      begin
        next_num = {num[22:0], 1'b0};
        if (trial >= {1'b0, lnk.invSet})
        begin
          next_rem = trial - {1'b0, lnk.invSet};
          next_quo = {quo[22:0], 1'b1};
        end
        else
        begin
          next_rem = trial;
          next_quo = {quo[22:0], 1'b0};
        end
        next_cnt = cnt + 5'h01;
        if (cnt == `NSP_DIV_LAST)
        begin
          next_state = NSP_DIV_IDLE;
          // zero setting gives all ones, i.e. saturated ratio
          next_ratio = (next_quo[23:16] != 8'h00) ? 16'hffff
                                                  : next_quo[15:0];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= NSP_DIV_IDLE;
      cnt   <= 5'h00;
      rem   <= 17'h0_0000;
      num   <= 24'h00_0000;
      quo   <= 24'h00_0000;
      ratio <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      rem   <= next_rem;
      num   <= next_num;
      quo   <= next_quo;
      ratio <= next_ratio;
    end
  end

  // rate per processing cycle, limit = K * multiplier * cycles per second
  always_comb
  begin
    sqFull = 32'(ratio) * 32'(ratio);
    sq = (sqFull[31:24] != 8'h00) ? 16'hffff : sqFull[23:8];
    unique case (lnk.curve)
      NSP_IEC_VI:
      begin
        kSel = `NSP_K_IEC_VI;
        lnk.incRate = (ratio > `NSP_Q8_ONE) ? ratio - `NSP_Q8_ONE : 16'h0000;
      end
      NSP_IEC_EI:
      begin
        kSel = `NSP_K_IEC_EI;
        lnk.incRate = (sq > `NSP_Q8_ONE) ? sq - `NSP_Q8_ONE : 16'h0000;
      end
      NSP_ANSI_VI:
      begin
        kSel = `NSP_K_ANSI_VI;
        lnk.incRate = (sq > `NSP_Q8_ONE) ? sq - `NSP_Q8_ONE : 16'h0000;
      end
      NSP_POWER:
      begin
        kSel = lnk.powerK;
        lnk.incRate = sq;
      end
    endcase
    // reset slope 1 - M^2, never zero so history always decays
    lnk.decRate = (sq < `NSP_Q8_ONE - 16'h0001) ? `NSP_Q8_ONE - sq
                                                : 16'h0001;
    kt = 32'(kSel) * 32'(lnk.timeMult);
    lnk.invLimit = 32'(40'(kt[31:8]) * 40'(`NSP_PROC_PER_S));
  end
endmodule : nsp_inv_curve

// ### tb/nsp_cur_src.sv
// partner: three-phase current source, four samples a period
`timescale 1ns/100ps
module nsp_cur_src (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [15:0]  amp,
  input  wire logic         neg,
  output logic              sampleValid,
  output nsp_pkg::nsp_smp_t sampleA,
  output nsp_pkg::nsp_smp_t sampleB,
  output nsp_pkg::nsp_smp_t sampleC
);
  import nsp_pkg::*;
  // cosines at quarter-period steps, x1000; neg swaps b and c
  int         tA [4] = '{1000, 0, -1000, 0};
  int         tL [4] = '{-500, 866, 500, -866};
  int         tR [4] = '{-500, -866, 500, 866};
  logic [2:0] step;
  function automatic nsp_smp_t sc(input int t);
    return nsp_smp_t'(int'(amp) * t / 1000);
  endfunction : sc
  // a sample every other clock; lines inverted between samples so a
  // stale value is never mistaken for a fresh one
  always @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      step <= 3'h0;
      sampleValid <= 1'b0;
      sampleA <= 16'h0000;
      sampleB <= 16'h0000;
      sampleC <= 16'h0000;
    end
    else
    begin
      step <= step + 3'h1;
      sampleValid <= ~step[0];
      sampleA <= step[0] ? ~sampleA : sc(tA[step[2:1]]);
      sampleB <= step[0] ? ~sampleB : sc(neg ? tR[step[2:1]] : tL[step[2:1]]);
      sampleC <= step[0] ? ~sampleC : sc(neg ? tL[step[2:1]] : tR[step[2:1]]);
    end
endmodule : nsp_cur_src

// ### tb/tb_top.sv
// self-checking bench for the negative sequence protection block
`timescale 1ns/100ps
module tb_top;
  import nsp_pkg::*;
  localparam int PD = 64;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        blockIn = 1'b0;
  logic        neg = 1'b0;
  logic [15:0] amp = 16'h0000;
  nsp_mode_t   mode = NSP_ON;
  nsp_curve_t  curve = NSP_IEC_VI;
  nsp_drop_t   dropMode = NSP_DROP_IMM;
  nsp_mag_t    rated = 16'h1000;
  nsp_mag_t    minSet = 16'h0064;
  nsp_mag_t    lowThr = 16'h03e8;
  nsp_mag_t    highThr = 16'h0bb8;
  nsp_mag_t    invSet = 16'hffff;
  logic        sampleValid;
  nsp_smp_t    sampleA;
  nsp_smp_t    sampleB;
  nsp_smp_t    sampleC;
  nsp_mag_t    i2;
  wire logic [6:0] obs; // relay, trips inv/high/low, pickups inv/high/low
  int          numErrors = 0;
  int          samplesChecked = 0;
  int          n;
  nsp_cur_src nsp_cur_src_inst (.mclk(mclk), .rst_b(rst_b), .amp(amp),
    .neg(neg), .sampleValid(sampleValid), .sampleA(sampleA),
    .sampleB(sampleB), .sampleC(sampleC));
  nsp_top #(.PROC_DIV(PD)) nsp_top_inst (.mclk(mclk), .rst_b(rst_b),
    .sampleValid(sampleValid), .sampleA(sampleA), .sampleB(sampleB),
    .sampleC(sampleC), .blockIn(blockIn), .mode(mode), .curve(curve),
    .dropMode(dropMode), .ratedCurrent(rated),
    .minimumCurrentSetting(minSet), .lowStageThreshold(lowThr),
    .highStageThreshold(highThr), .lowStageDelay(16'h0003),
    .highStageDelay(16'h0002), .inverseStageSetting(invSet),
    .timeMultiplier(16'h0001), .powerConstant(16'h0100),
    .negativeSequenceCurrent(i2), .lowPickup(obs[0]),
    .highPickup(obs[1]), .invPickup(obs[2]), .lowTrip(obs[3]),
    .highTrip(obs[4]), .invTrip(obs[5]), .tripRelay(obs[6]));
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    samplesChecked++;
    if (s !== e)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic s, input logic e);
    chk(nm, {15'h0000, s}, {15'h0000, e});
  endtask : chkb
  // land just after the edge so registered outputs have settled
  task automatic tick(input int t);
    repeat (t) @(posedge mclk);
    #1;
  endtask : tick
  task automatic waitHi(input int idx, input int lim);
    n = 0;
    while (obs[idx] !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask : waitHi
  task automatic setAmp(input logic [15:0] a);
    @(posedge mclk);
    amp <= a;
  endtask : setAmp
  task automatic wrapUp;
    if (numErrors == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrapUp
  initial forever #2 mclk = ~mclk;
  // bound far above the expected run of about 30k cycles
  initial
  begin
    repeat (60000) @(posedge mclk);
    numErrors++;
    wrapUp;
  end
  // main sequence: balanced, then unbalanced, then each stage in turn
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    tick(1);
    chk("reset", {9'h000, obs}, 16'h0000);
    setAmp(16'h03e8);
    tick(3 * PD);
    chkb("i2 balanced", i2 < 16'h00c8, 1'b1);
    chkb("low pu bal", obs[0], 1'b0);
    @(posedge mclk);
    neg <= 1'b1;
    waitHi(0, 4 * PD);
    chkb("low pu", obs[0], 1'b1);
    chkb("high pu", obs[1], 1'b0);
    tick(2 * PD - 2);
    chkb("low trip early", obs[3], 1'b0);
    tick(2);
    chkb("low trip", obs[3], 1'b1);
    tick(1);
    chkb("relay", obs[6], 1'b1);
    chkb("i2 window", i2 > 16'h0708 && i2 < 16'h0898, 1'b1);
    @(posedge mclk);
    highThr <= 16'h05dc;
    waitHi(1, 2 * PD);
    chkb("high pu", obs[1], 1'b1);
    waitHi(4, 3 * PD);
    chkb("high trip", obs[4], 1'b1);
    chkb("low kept", obs[3], 1'b1);
    @(posedge mclk);
    mode <= NSP_RELAY_BLK;
    tick(4);
    chkb("relay held", obs[6], 1'b0);
    chkb("trip flag", obs[3], 1'b1);
    @(posedge mclk);
    mode <= NSP_ON;
    blockIn <= 1'b1;
    tick(8);
    chk("blocked", {9'h000, obs}, 16'h0000);
    tick(3 * PD);
    chk("still blocked", {9'h000, obs}, 16'h0000);
    @(posedge mclk);
    blockIn <= 1'b0;
    waitHi(0, 3 * PD);
    tick(PD);
    chkb("timer restarted", obs[3], 1'b0);
    @(posedge mclk);
    mode <= NSP_OFF;
    tick(2);
    chk("mode off", {9'h000, obs}, 16'h0000);
    @(posedge mclk);
    mode <= NSP_ON;
    rated <= 16'h01c2;
    tick(2 * PD);
    chk("over range", {9'h000, obs}, 16'h0000);
    @(posedge mclk);
    rated <= 16'h1000;
    minSet <= 16'h0bb8;
    tick(2 * PD);
    chk("under minimum", {9'h000, obs}, 16'h0000);
    @(posedge mclk);
    minSet <= 16'h0064;
    lowThr <= 16'hffff;
    highThr <= 16'hffff;
    invSet <= 16'h076c;
    tick(3 * PD);
    chkb("inv below", obs[2], 1'b0);
    @(posedge mclk);
    invSet <= 16'h06a4;
    waitHi(2, 3 * PD);
    chkb("inv pu", obs[2], 1'b1);
    // every curve, each from a cleared accumulator
    @(posedge mclk);
    invSet <= 16'h07d0;
    for (int c = 0; c < 5; c++)
    begin
      setAmp(16'h0000);
      tick(3 * PD);
      @(posedge mclk);
      curve <= nsp_curve_t'(c % 4);
      amp <= 16'h07d0;
      waitHi(5, 150 * PD);
      chkb("inv trip", obs[5], 1'b1);
      if (c % 4 == 0)
        chkb("inv delay", n > 30 * PD, 1'b1);
    end
    setAmp(16'h0384);
    tick(2 * PD);
    chkb("imm drop", obs[2], 1'b0);
    setAmp(16'h07d0);
    waitHi(2, 3 * PD);
    tick(20 * PD);
    chkb("imm restart", obs[5], 1'b0);
    @(posedge mclk);
    dropMode <= NSP_DROP_DISK;
    waitHi(5, 150 * PD);
    setAmp(16'h039d);
    tick(40 * PD);
    chkb("disk drop", obs[2], 1'b0);
    setAmp(16'h07d0);
    waitHi(5, 4 * PD);
    chkb("disk held", obs[5], 1'b1);
    setAmp(16'h02bc);
    tick(30 * PD);
    setAmp(16'h07d0);
    waitHi(5, 60 * PD);
    chkb("disk decay", n > 5 * PD && n < 40 * PD, 1'b1);
    setAmp(16'h0000);
    tick(3 * PD);
    setAmp(16'h07d0);
    waitHi(2, 3 * PD);
    tick(20 * PD);
    chkb("disk cleared", obs[5], 1'b0);
    wrapUp;
  end
endmodule : tb_top
